/* File: design/port_pkg.sv */
package port_pkg;
  localparam int unsigned PORT_WIDTH = 8;
  // register indices on the core data port
  localparam logic [2:0] ADDR_A_LEVEL = 3'h0;
  localparam logic [2:0] ADDR_B_LEVEL = 3'h1;
  localparam logic [2:0] ADDR_C_LEVEL = 3'h2;
  localparam logic [2:0] ADDR_A_DIR   = 3'h4;
  localparam logic [2:0] ADDR_B_DIR   = 3'h5;
  localparam logic [2:0] ADDR_C_DIR   = 3'h6;
  // reset values
  localparam logic [7:0] LEVEL_RESET  = 8'h00;
  localparam logic [7:0] DIR_RESET    = 8'h00;
  localparam logic [7:0] C_DIR_RESET  = 8'h04;
  // fixed drive type per pin, 1 = push-pull, 0 = open-drain
  localparam logic [7:0] A_PUSH_PULL  = 8'h00;
  localparam logic [7:0] B_PUSH_PULL  = 8'h0f;
  localparam logic [7:0] C_PUSH_PULL  = 8'h14;
  // pins that have an on-chip pull-up
  localparam logic [7:0] A_HAS_PULLUP = 8'h00;
  localparam logic [7:0] B_HAS_PULLUP = 8'h0f;
  localparam logic [7:0] C_HAS_PULLUP = 8'h7c;
  // overlay lines: blank, red, green on port c, vsync and hsync on port b
  localparam int unsigned BLANK_BIT   = 3;
  localparam int unsigned RED_BIT     = 5;
  localparam int unsigned GREEN_BIT   = 6;
  localparam int unsigned VSYNC_BIT   = 2;
  localparam int unsigned HSYNC_BIT   = 3;

  typedef struct packed {
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } core_req_t;

  typedef struct packed {
    logic blank;
    logic red;
    logic green;
  } overlay_t;
endpackage

/* File: design/port_line_slice.sv */
module port_line_slice #(
  parameter int unsigned      WIDTH      = 8,
  parameter logic [WIDTH-1:0] PUSH_PULL  = '0,
  parameter logic [WIDTH-1:0] HAS_PULLUP = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] level,
  input  wire logic [WIDTH-1:0] dir,
  input  wire logic [WIDTH-1:0] overlay_and,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  output logic      [WIDTH-1:0] pullup_en
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] out_next;
  logic [WIDTH-1:0] oe_next;
  logic [WIDTH-1:0] pu_next;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] oe_reg;
  logic [WIDTH-1:0] pu_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_line
      // drive level is data and overlay ANDed
      wire drive_val = level[i] & overlay_and[i];
      // push-pull drives both levels, open-drain only pulls low
      assign out_next[i] = PUSH_PULL[i] ? drive_val : 1'b0;
      assign oe_next[i]  = dir[i] & (PUSH_PULL[i] | ~drive_val);
      // pull-up on inputs with level bit low, where fitted
      assign pu_next[i]  = ~dir[i] & ~level[i] & HAS_PULLUP[i];
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
      out_reg  <= '0;
      oe_reg   <= '0;
      pu_reg   <= '0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      out_reg  <= out_next;
      oe_reg   <= oe_next;
      pu_reg   <= pu_next;
    end
  end

  assign pin_sync  = sync_reg;
  assign pin_out   = out_reg;
  assign pin_oe    = oe_reg;
  assign pullup_en = pu_reg;
endmodule

/* File: design/tri_port_io_with_overlay_mux.sv */
// Overview of operation
// - every line's direction set independently
// - input: level bit 0 pull-up, 1 none
// - drive type fixed per pin
// - port a open-drain only, no pull-up
// - bit n of both registers controls line n
// - level read returns pin state for inputs
// - level write sets output drive value
// - direction bit 0 input, 1 output
// - registers accessed like plain data locations
// - six registers, level and direction per port
// - reset clears registers except port c direction bit 2, inputs with pull-up where fitted
// - power switch line resets output driven low
// - overlay lines are overlay ANDed with data
// - sync inputs and overlay outputs routed fixed
// - pull-up only on inputs where fitted
module tri_port_io_with_overlay_mux #(
  parameter int unsigned WIDTH = port_pkg::PORT_WIDTH
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire port_pkg::core_req_t core_req,
  output logic [7:0]               core_rdata,
  input  wire port_pkg::overlay_t  overlay_in,
  output logic                     overlay_vsync,
  output logic                     overlay_hsync,
  input  wire logic [WIDTH-1:0]    port_a_lines_in,
  output logic [WIDTH-1:0]         port_a_lines_out,
  output logic [WIDTH-1:0]         port_a_lines_oe,
  output logic [WIDTH-1:0]         port_a_pullup,
  input  wire logic [WIDTH-1:0]    port_b_lines_in,
  output logic [WIDTH-1:0]         port_b_lines_out,
  output logic [WIDTH-1:0]         port_b_lines_oe,
  output logic [WIDTH-1:0]         port_b_pullup,
  input  wire logic [WIDTH-1:0]    port_c_lines_in,
  output logic [WIDTH-1:0]         port_c_lines_out,
  output logic [WIDTH-1:0]         port_c_lines_oe,
  output logic [WIDTH-1:0]         port_c_pullup
);
  logic [WIDTH-1:0] port_a_level_reg;
  logic [WIDTH-1:0] port_b_level_reg;
  logic [WIDTH-1:0] port_c_level_reg;
  logic [WIDTH-1:0] port_a_direction_reg;
  logic [WIDTH-1:0] port_b_direction_reg;
  logic [WIDTH-1:0] port_c_direction_reg;
  logic [7:0]       rdata_reg;
  logic [7:0]       rdata_next;
  logic             vsync_reg;
  logic             hsync_reg;
  logic [WIDTH-1:0] a_sync;
  logic [WIDTH-1:0] b_sync;
  logic [WIDTH-1:0] c_sync;
  logic [WIDTH-1:0] c_overlay_and;
  logic [WIDTH-1:0] ones;

  // register decode, six locations
  wire wr_a_level = core_req.wr && core_req.addr == port_pkg::ADDR_A_LEVEL;
  wire wr_b_level = core_req.wr && core_req.addr == port_pkg::ADDR_B_LEVEL;
  wire wr_c_level = core_req.wr && core_req.addr == port_pkg::ADDR_C_LEVEL;
  wire wr_a_dir   = core_req.wr && core_req.addr == port_pkg::ADDR_A_DIR;
  wire wr_b_dir   = core_req.wr && core_req.addr == port_pkg::ADDR_B_DIR;
  wire wr_c_dir   = core_req.wr && core_req.addr == port_pkg::ADDR_C_DIR;

  // pin level for inputs, stored bit for outputs
  wire [WIDTH-1:0] a_view = (a_sync & ~port_a_direction_reg) | (port_a_level_reg & port_a_direction_reg);
  wire [WIDTH-1:0] b_view = (b_sync & ~port_b_direction_reg) | (port_b_level_reg & port_b_direction_reg);
  wire [WIDTH-1:0] c_view = (c_sync & ~port_c_direction_reg) | (port_c_level_reg & port_c_direction_reg);

  assign ones = '1;

  // overlay signals wired-AND into port c
  always_comb begin
    c_overlay_and = ones;
    c_overlay_and[port_pkg::BLANK_BIT] = overlay_in.blank;
    c_overlay_and[port_pkg::RED_BIT]   = overlay_in.red;
    c_overlay_and[port_pkg::GREEN_BIT] = overlay_in.green;
  end

  // read mux, registered, data one cycle after address
  always_comb begin
    case (core_req.addr)
      port_pkg::ADDR_A_LEVEL: rdata_next = 8'(a_view);
      port_pkg::ADDR_B_LEVEL: rdata_next = 8'(b_view);
      port_pkg::ADDR_C_LEVEL: rdata_next = 8'(c_view);
      port_pkg::ADDR_A_DIR:   rdata_next = 8'(port_a_direction_reg);
      port_pkg::ADDR_B_DIR:   rdata_next = 8'(port_b_direction_reg);
      port_pkg::ADDR_C_DIR:   rdata_next = 8'(port_c_direction_reg);
      default:                rdata_next = 8'h00;
    endcase
  end

  // register writes on the clock edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      port_a_level_reg     <= WIDTH'(port_pkg::LEVEL_RESET);
      port_b_level_reg     <= WIDTH'(port_pkg::LEVEL_RESET);
      port_c_level_reg     <= WIDTH'(port_pkg::LEVEL_RESET);
      port_a_direction_reg <= WIDTH'(port_pkg::DIR_RESET);
      port_b_direction_reg <= WIDTH'(port_pkg::DIR_RESET);
      port_c_direction_reg <= WIDTH'(port_pkg::C_DIR_RESET);
    end else begin
      if (wr_a_level) port_a_level_reg <= WIDTH'(core_req.wdata);
      if (wr_b_level) port_b_level_reg <= WIDTH'(core_req.wdata);
      if (wr_c_level) port_c_level_reg <= WIDTH'(core_req.wdata);
      if (wr_a_dir) port_a_direction_reg <= WIDTH'(core_req.wdata);
      if (wr_b_dir) port_b_direction_reg <= WIDTH'(core_req.wdata);
      if (wr_c_dir) port_c_direction_reg <= WIDTH'(core_req.wdata);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
      vsync_reg <= 1'b0;
      hsync_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      // sync pins feed overlay, valid when lines are inputs
      vsync_reg <= b_sync[port_pkg::VSYNC_BIT];
      hsync_reg <= b_sync[port_pkg::HSYNC_BIT];
    end
  end

  assign core_rdata    = rdata_reg;
  assign overlay_vsync = vsync_reg;
  assign overlay_hsync = hsync_reg;

  port_line_slice #(
    .WIDTH      (WIDTH),
    .PUSH_PULL  (WIDTH'(port_pkg::A_PUSH_PULL)),
    .HAS_PULLUP (WIDTH'(port_pkg::A_HAS_PULLUP))
  ) u_port_a (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .level       (port_a_level_reg),
    .dir         (port_a_direction_reg),
    .overlay_and (ones),
    .pin_in      (port_a_lines_in),
    .pin_sync    (a_sync),
    .pin_out     (port_a_lines_out),
    .pin_oe      (port_a_lines_oe),
    .pullup_en   (port_a_pullup)
  );

  port_line_slice #(
    .WIDTH      (WIDTH),
    .PUSH_PULL  (WIDTH'(port_pkg::B_PUSH_PULL)),
    .HAS_PULLUP (WIDTH'(port_pkg::B_HAS_PULLUP))
  ) u_port_b (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .level       (port_b_level_reg),
    .dir         (port_b_direction_reg),
    .overlay_and (ones),
    .pin_in      (port_b_lines_in),
    .pin_sync    (b_sync),
    .pin_out     (port_b_lines_out),
    .pin_oe      (port_b_lines_oe),
    .pullup_en   (port_b_pullup)
  );

  port_line_slice #(
    .WIDTH      (WIDTH),
    .PUSH_PULL  (WIDTH'(port_pkg::C_PUSH_PULL)),
    .HAS_PULLUP (WIDTH'(port_pkg::C_HAS_PULLUP))
  ) u_port_c (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .level       (port_c_level_reg),
    .dir         (port_c_direction_reg),
    .overlay_and (c_overlay_and),
    .pin_in      (port_c_lines_in),
    .pin_sync    (c_sync),
    .pin_out     (port_c_lines_out),
    .pin_oe      (port_c_lines_oe),
    .pullup_en   (port_c_pullup)
  );
endmodule

/* File: sim/tri_port_props.sv */
module tri_port_props #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire port_pkg::core_req_t core_req,
  input wire logic [7:0]          core_rdata,
  input wire logic                overlay_vsync,
  input wire logic                overlay_hsync,
  input wire logic [WIDTH-1:0]    port_a_lines_out,
  input wire logic [WIDTH-1:0]    port_a_pullup,
  input wire logic [WIDTH-1:0]    port_b_lines_in,
  input wire logic [WIDTH-1:0]    port_b_lines_oe,
  input wire logic [WIDTH-1:0]    port_b_pullup,
  input wire logic [WIDTH-1:0]    port_c_pullup
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] up_cnt;
  // cycles since reset release, saturating
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      up_cnt <= 3'h0;
    end else if (up_cnt != 3'h4) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence wr_b_dir;
    core_req.wr && core_req.addr == port_pkg::ADDR_B_DIR;
  endsequence
  sequence rd_b_dir;
    !core_req.wr && core_req.addr == port_pkg::ADDR_B_DIR;
  endsequence
  chk_a_no_pullup: assert property (port_a_pullup == 8'h00)
    else $error("port a pull-up on");
  chk_a_open_drain: assert property (port_a_lines_out == 8'h00)
    else $error("port a drives high");
  chk_pullup_inputs: assert property ((port_b_pullup & port_b_lines_oe) == 8'h00)
    else $error("pull-up on output line");
  chk_pullup_fitted: assert property ((port_b_pullup & 8'hf0) == 8'h00 && (port_c_pullup & 8'h83) == 8'h00)
    else $error("pull-up on unfitted line");
  chk_vsync_route: assert property (up_cnt == 3'h4 |-> overlay_vsync == $past(port_b_lines_in[2], 3))
    else $error("vsync not routed");
  chk_hsync_route: assert property (up_cnt == 3'h4 |-> overlay_hsync == $past(port_b_lines_in[3], 3))
    else $error("hsync not routed");
  chk_dir_to_oe: assert property (wr_b_dir |-> ##2 port_b_lines_oe[3:0] == $past(core_req.wdata[3:0], 2))
    else $error("direction write not on oe");
  chk_dir_readback: assert property (wr_b_dir ##1 rd_b_dir |=> core_rdata == $past(core_req.wdata, 2))
    else $error("direction readback wrong");
  chk_unmapped_read: assert property (!core_req.wr && core_req.addr[1:0] == 2'h3 |=> core_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind tri_port_io_with_overlay_mux tri_port_props #(.WIDTH(WIDTH)) props_u (.ref_clk, .rst, .core_req, .core_rdata,
  .overlay_vsync, .overlay_hsync, .port_a_lines_out, .port_a_pullup, .port_b_lines_in, .port_b_lines_oe,
  .port_b_pullup, .port_c_pullup);

/* File: sim/board_pins_model.sv */
module board_pins_model #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic [WIDTH-1:0] lines_out,
  input wire logic [WIDTH-1:0] lines_oe,
  input wire logic [WIDTH-1:0] ext_drive,
  output logic     [WIDTH-1:0] lines_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // pin level: device drive where enabled, else board drive
  assign lines_in = (lines_oe & lines_out) | (~lines_oe & ext_drive);
endmodule

/* File: sim/tri_port_io_with_overlay_mux_tb.sv */
module tri_port_io_with_overlay_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                ref_clk, rst, vsync, hsync;
  port_pkg::core_req_t core_req;
  port_pkg::overlay_t  overlay_in;
  logic [7:0]          rdata, ext_a, ext_b, ext_c, d;
  logic [7:0]          a_in, a_out, a_oe, a_pu, b_in, b_out, b_oe, b_pu, c_in, c_out, c_oe, c_pu;
  int                  n_errors, check_count;
  tri_port_io_with_overlay_mux dut_u (.ref_clk(ref_clk), .rst(rst), .core_req(core_req), .core_rdata(rdata),
    .overlay_in(overlay_in), .overlay_vsync(vsync), .overlay_hsync(hsync),
    .port_a_lines_in(a_in), .port_a_lines_out(a_out), .port_a_lines_oe(a_oe), .port_a_pullup(a_pu),
    .port_b_lines_in(b_in), .port_b_lines_out(b_out), .port_b_lines_oe(b_oe), .port_b_pullup(b_pu),
    .port_c_lines_in(c_in), .port_c_lines_out(c_out), .port_c_lines_oe(c_oe), .port_c_pullup(c_pu));
  board_pins_model pa_u (.lines_out(a_out), .lines_oe(a_oe), .ext_drive(ext_a), .lines_in(a_in));
  board_pins_model pb_u (.lines_out(b_out), .lines_oe(b_oe), .ext_drive(ext_b), .lines_in(b_in));
  board_pins_model pc_u (.lines_out(c_out), .lines_oe(c_oe), .ext_drive(ext_c), .lines_in(c_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    core_req <= '{wr: 1'b1, addr: a, wdata: v};
    @(posedge ref_clk);
    core_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge ref_clk);
    core_req <= '{wr: 1'b0, addr: a, wdata: 8'h00};
    repeat (2) @(posedge ref_clk);
    #1 d = rdata;
  endtask
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic reset_values;
    chk(c_oe, 8'h04);
    chk(c_out & c_oe, 8'h00);
    chk(a_oe | b_oe, 8'h00);
    chk(a_pu | b_pu, 8'h0f);
    chk(c_pu, 8'h78);
    rd(port_pkg::ADDR_C_DIR); chk(d, 8'h04);
    rd(port_pkg::ADDR_B_DIR); chk(d, 8'h00);
  endtask
  task automatic drive_modes;
    wr(port_pkg::ADDR_A_DIR, 8'hff);
    wr(port_pkg::ADDR_A_LEVEL, 8'h0f);
    wr(port_pkg::ADDR_B_DIR, 8'h03);
    wr(port_pkg::ADDR_B_LEVEL, 8'h01);
    settle;
    chk(a_oe, 8'hf0);
    chk(b_oe, 8'h03);
    chk(b_out & b_oe, 8'h01);
    chk(b_pu, 8'h0c);
    rd(port_pkg::ADDR_A_LEVEL); chk(d, 8'h0f);
  endtask
  task automatic pin_reads;
    @(posedge ref_clk);
    ext_b <= 8'ha4;
    settle;
    chk({6'h00, vsync, hsync}, 8'h02);
    rd(port_pkg::ADDR_B_LEVEL); chk(d, 8'ha5);
    // bit-set style write-back copies pin levels into the level bits of the input lines
    wr(port_pkg::ADDR_B_LEVEL, d);
    settle;
    chk(b_pu, 8'h08);
    @(posedge ref_clk);
    ext_b <= 8'h08;
    settle;
    chk({6'h00, vsync, hsync}, 8'h01);
  endtask
  task automatic overlay_mix;
    wr(port_pkg::ADDR_C_DIR, 8'h6c);
    wr(port_pkg::ADDR_C_LEVEL, 8'h28);
    overlay_in <= '{blank: 1'b1, red: 1'b1, green: 1'b1};
    settle;
    chk(c_oe & 8'h6c, 8'h44);
    @(posedge ref_clk);
    overlay_in <= '{blank: 1'b0, red: 1'b1, green: 1'b1};
    settle;
    chk(c_oe & 8'h6c, 8'h4c);
    @(posedge ref_clk);
    overlay_in <= '{blank: 1'b1, red: 1'b0, green: 1'b1};
    settle;
    chk(c_oe & 8'h6c, 8'h64);
    rd(port_pkg::ADDR_C_LEVEL); chk(d, 8'ha9);
  endtask
  task automatic unmapped_access;
    wr(3'h3, 8'hff);
    wr(3'h7, 8'hff);
    rd(3'h3); chk(d, 8'h00);
    rd(3'h7); chk(d, 8'h00);
    rd(port_pkg::ADDR_B_DIR); chk(d, 8'h03);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    #20us;
    n_errors++;
    $display("BAD %0t timeout", $time);
    results;
  end
  initial begin
    rst = 1'b1;
    core_req = '0;
    overlay_in = '0;
    ext_a = 8'h3c;
    ext_b = 8'h00;
    ext_c = 8'h81;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    reset_values;
    drive_modes;
    pin_reads;
    overlay_mix;
    unmapped_access;
    results;
  end
endmodule
